// >>> hw/i2c_seg_map.svh
// register offsets, field positions, reset values and timing for the segment engine
`ifndef I2C_SEG_MAP_SVH
`define I2C_SEG_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SEG_DATA_OFS 8'h3C
`define SEG_STATUS_OFS 8'h44
`define SEG_CMD_OFS 8'h4C
`define SEG_ACKCTL_OFS 8'h50

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMD_STOP_BIT 3
`define CMD_START_BIT 2
`define CMD_SEND_BIT 1
`define CMD_RECV_BIT 0
`define STAT_CMDFIN_BIT 3
`define STAT_RXFIN_BIT 2
`define STAT_TXFIN_BIT 1
`define STAT_NAK_BIT 0
`define ACK_SEL_BIT 0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SEG_CMD_RST 4'h0
`define SEG_STAT_RST 4'h0
`define SEG_DATA_RST 8'h00
`define SEG_ACK_RST 1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCL_QUARTER_NS 2500
`define LINK_CLK_PS 6000

`endif

// >>> hw/i2c_seg_pkg.sv
// types shared by the segment engine files
package i2c_seg_pkg;
  typedef enum logic [3:0] {
    ENG_IDLE = 4'h1,
    ENG_START = 4'h2,
    ENG_BYTE = 4'h4,
    ENG_STOP = 4'h8
  } engine_state_e;
  typedef logic [3:0] seg_cmd_t;
  typedef logic [7:0] byte_t;
endpackage

// >>> hw/seg_sync2.sv
// two flip-flop synchroniser for levels entering a clock domain
`timescale 1ns/1ps
module seg_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    sync_reg <= meta_reg;
  end

  assign q_o = sync_reg;
endmodule

// >>> hw/i2c_master_segment_engine.sv
// two-wire bus master driven by software-issued segments, wishbone register side
//
// What this block does
// - a lone start bit makes a start or repeated start, a lone send bit sends a byte, a lone receive bit receives one.
// - a lone stop bit makes a stop condition that ends the frame.
// - with no command bit set nothing is pending and the lines are left as they are.
// - after each received byte the block drives ack when ack select is 1 and nack when it is 0.
// - sent and received bytes both pass through the one shared byte register.
// - start and stop are issued by setting the bit and waiting for it to clear or for command done.
// - a send is data write, then send bit, then wait for the bit to clear or send done.
// - a receive is receive bit, wait for clear or receive done, then read the byte register.
// - after a sent byte the slave nack flag shows nack as set and ack as clear.
// - each command bit clears by itself when its segment has completed.
// - the four status flags stay set until the next segment begins and then clear.
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "i2c_seg_map.svh"
module i2c_master_segment_engine #(
  parameter int QUARTER_CYCLES = (`SCL_QUARTER_NS * 1000 + `LINK_CLK_PS - 1) / `LINK_CLK_PS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_clk_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  localparam int CW = $clog2(QUARTER_CYCLES + 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic one_hot4(input i2c_seg_pkg::seg_cmd_t c);
    return (c != 4'h0) && ((c & (c - 4'h1)) == 4'h0);
  endfunction

  // ----------------------------------------------------------------
  // bus domain state
  // ----------------------------------------------------------------
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  i2c_seg_pkg::seg_cmd_t cmd_reg, cmd_next;
  i2c_seg_pkg::byte_t data_reg, data_next;
  i2c_seg_pkg::byte_t hold_tx_reg, hold_tx_next;
  logic ack_sel_reg, ack_sel_next;
  logic hold_ack_reg, hold_ack_next;
  logic [3:0] stat_reg, stat_next;
  logic req_tgl_reg, req_tgl_next;
  logic done_seen_reg, done_seen_next;
  logic done_s;
  logic done_evt;
  logic wr;
  logic launch;

  // ----------------------------------------------------------------
  // link domain state
  // ----------------------------------------------------------------
  i2c_seg_pkg::engine_state_e state_reg, state_next;
  logic [1:0] phase_reg, phase_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  i2c_seg_pkg::byte_t shift_reg, shift_next;
  i2c_seg_pkg::byte_t rxb_reg, rxb_next;
  logic nack_reg, nack_next;
  logic scl_oe_reg, scl_oe_next;
  logic sda_oe_reg, sda_oe_next;
  logic req_seen_reg, req_seen_next;
  logic done_tgl_reg, done_tgl_next;
  logic lrst, req_s, scl_s, sda_s;
  logic tick, stall, step;

  // ----------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------
  seg_sync2 #(.WIDTH(4)) u_to_link (
    .clk_i(link_clk_i),
    .d_i({rst_i, req_tgl_reg, scl_i, sda_i}),
    .q_o({lrst, req_s, scl_s, sda_s})
  );

  seg_sync2 #(.WIDTH(1)) u_to_bus (
    .clk_i(clk_i),
    .d_i(done_tgl_reg),
    .q_o(done_s)
  );

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_word(input logic [7:0] adr);
    case (adr)
      `SEG_DATA_OFS: rd_word = {24'h000000, data_reg};
      `SEG_STATUS_OFS: rd_word = {28'h0000000, stat_reg};
      `SEG_CMD_OFS: rd_word = {28'h0000000, cmd_reg};
      `SEG_ACKCTL_OFS: rd_word = {31'h00000000, ack_sel_reg};
      default: rd_word = 32'h00000000;
    endcase
  endfunction

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];
  assign done_evt = done_s ^ done_seen_reg;
  assign launch = wr && (wb_adr_i == `SEG_CMD_OFS) && (cmd_reg == 4'h0) &&
                  one_hot4(wb_dat_i[3:0]);

  always_comb begin
    ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
    rdat_next = rdat_reg;
    cmd_next = cmd_reg;
    data_next = data_reg;
    hold_tx_next = hold_tx_reg;
    ack_sel_next = ack_sel_reg;
    hold_ack_next = hold_ack_reg;
    stat_next = stat_reg;
    req_tgl_next = req_tgl_reg;
    done_seen_next = done_s;
    if (wb_cyc_i & wb_stb_i & ~ack_reg) begin
      rdat_next = rd_word(wb_adr_i);
    end
    if (wr && (wb_adr_i == `SEG_DATA_OFS)) begin
      data_next = wb_dat_i[7:0];
    end
    if (wr && (wb_adr_i == `SEG_ACKCTL_OFS)) begin
      ack_sel_next = wb_dat_i[`ACK_SEL_BIT];
    end
    if (launch) begin
      cmd_next = wb_dat_i[3:0];
      hold_tx_next = data_reg;
      hold_ack_next = ack_sel_reg;
      stat_next = `SEG_STAT_RST;
      req_tgl_next = ~req_tgl_reg;
    end
    if (done_evt) begin
      cmd_next = `SEG_CMD_RST;
      if (cmd_reg[`CMD_START_BIT] | cmd_reg[`CMD_STOP_BIT]) begin
        stat_next[`STAT_CMDFIN_BIT] = 1'b1;
      end
      if (cmd_reg[`CMD_SEND_BIT]) begin
        stat_next[`STAT_TXFIN_BIT] = 1'b1;
        stat_next[`STAT_NAK_BIT] = nack_reg;
      end
      if (cmd_reg[`CMD_RECV_BIT]) begin
        stat_next[`STAT_RXFIN_BIT] = 1'b1;
        data_next = rxb_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
      cmd_reg <= `SEG_CMD_RST;
      data_reg <= `SEG_DATA_RST;
      hold_tx_reg <= `SEG_DATA_RST;
      ack_sel_reg <= `SEG_ACK_RST;
      hold_ack_reg <= `SEG_ACK_RST;
      stat_reg <= `SEG_STAT_RST;
      req_tgl_reg <= 1'b0;
      done_seen_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      cmd_reg <= cmd_next;
      data_reg <= data_next;
      hold_tx_reg <= hold_tx_next;
      ack_sel_reg <= ack_sel_next;
      hold_ack_reg <= hold_ack_next;
      stat_reg <= stat_next;
      req_tgl_reg <= req_tgl_next;
      done_seen_reg <= done_seen_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ----------------------------------------------------------------
  // segment engine on the link clock
  // ----------------------------------------------------------------
  assign tick = (cnt_reg == CW'(QUARTER_CYCLES - 1));
  assign stall = (phase_reg == 2'd2) && !scl_s;
  assign step = tick & ~stall;

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    shift_next = shift_reg;
    rxb_next = rxb_reg;
    nack_next = nack_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    req_seen_next = req_seen_reg;
    done_tgl_next = done_tgl_reg;
    if (state_reg != i2c_seg_pkg::ENG_IDLE && !stall) begin
      cnt_next = tick ? '0 : cnt_reg + CW'(1);
    end
    case (state_reg)
      i2c_seg_pkg::ENG_IDLE: begin
        cnt_next = '0;
        phase_next = 2'd0;
        bit_next = 4'd0;
        if (req_s != req_seen_reg) begin
          req_seen_next = req_s;
          shift_next = hold_tx_reg;
          if (cmd_reg[`CMD_START_BIT]) begin
            state_next = i2c_seg_pkg::ENG_START;
          end else if (cmd_reg[`CMD_STOP_BIT]) begin
            state_next = i2c_seg_pkg::ENG_STOP;
          end else begin
            state_next = i2c_seg_pkg::ENG_BYTE;
          end
        end
      end
      i2c_seg_pkg::ENG_START: begin
        if (step) begin
          phase_next = phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_oe_next = 1'b0;
            2'd1: scl_oe_next = 1'b0;
            2'd2: sda_oe_next = 1'b1;
            default: begin
              scl_oe_next = 1'b1;
              done_tgl_next = ~done_tgl_reg;
              state_next = i2c_seg_pkg::ENG_IDLE;
            end
          endcase
        end
      end
      i2c_seg_pkg::ENG_STOP: begin
        if (step) begin
          phase_next = phase_reg + 2'd1;
          case (phase_reg)
            2'd0: sda_oe_next = 1'b1;
            2'd1: scl_oe_next = 1'b0;
            2'd2: sda_oe_next = 1'b0;
            default: begin
              done_tgl_next = ~done_tgl_reg;
              state_next = i2c_seg_pkg::ENG_IDLE;
            end
          endcase
        end
      end
      i2c_seg_pkg::ENG_BYTE: begin
        if (step) begin
          phase_next = phase_reg + 2'd1;
          case (phase_reg)
            2'd0: begin
              if (bit_reg == 4'd8) begin
                sda_oe_next = cmd_reg[`CMD_RECV_BIT] & hold_ack_reg;
              end else begin
                sda_oe_next = cmd_reg[`CMD_SEND_BIT] & ~shift_reg[7];
              end
            end
            2'd1: scl_oe_next = 1'b0;
            2'd2: begin
              if (bit_reg == 4'd8) begin
                nack_next = sda_s;
              end else begin
                shift_next = {shift_reg[6:0], sda_s};
              end
            end
            default: begin
              scl_oe_next = 1'b1;
              bit_next = bit_reg + 4'd1;
              if (bit_reg == 4'd8) begin
                rxb_next = shift_reg;
                done_tgl_next = ~done_tgl_reg;
                state_next = i2c_seg_pkg::ENG_IDLE;
              end
            end
          endcase
        end
      end
      default: state_next = i2c_seg_pkg::ENG_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      state_reg <= i2c_seg_pkg::ENG_IDLE;
      phase_reg <= 2'd0;
      cnt_reg <= '0;
      bit_reg <= 4'd0;
      shift_reg <= 8'h00;
      rxb_reg <= 8'h00;
      nack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      req_seen_reg <= 1'b0;
      done_tgl_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      rxb_reg <= rxb_next;
      nack_reg <= nack_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      req_seen_reg <= req_seen_next;
      done_tgl_reg <= done_tgl_next;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_oe_reg;
  assign sda_oe_o = sda_oe_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_start_cond;
    @(posedge link_clk_i) disable iff (lrst)
    (state_reg == i2c_seg_pkg::ENG_START && phase_reg == 2'd2 && step)
      |=> (sda_oe_reg && !scl_oe_reg);
  endproperty
  a_start_cond: assert property (p_start_cond) else $error("start edge missing");

  property p_stop_cond;
    @(posedge link_clk_i) disable iff (lrst)
    (state_reg == i2c_seg_pkg::ENG_STOP && phase_reg == 2'd2 && step)
      |=> (!sda_oe_reg && !scl_oe_reg);
  endproperty
  a_stop_cond: assert property (p_stop_cond) else $error("stop edge missing");

  property p_idle_quiet;
    @(posedge link_clk_i) disable iff (lrst)
    (state_reg == i2c_seg_pkg::ENG_IDLE && req_s == req_seen_reg)
      |=> ($stable(sda_oe_reg) && $stable(scl_oe_reg));
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("lines moved while idle");

  property p_ack_drive;
    @(posedge link_clk_i) disable iff (lrst)
    (state_reg == i2c_seg_pkg::ENG_BYTE && cmd_reg[`CMD_RECV_BIT] && bit_reg == 4'd8 &&
     phase_reg == 2'd2) |-> (sda_oe_reg == hold_ack_reg);
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("wrong ack level");

  property p_send_bit;
    @(posedge link_clk_i) disable iff (lrst)
    (state_reg == i2c_seg_pkg::ENG_BYTE && cmd_reg[`CMD_SEND_BIT] && bit_reg < 4'd8 &&
     phase_reg == 2'd2) |-> (sda_oe_reg == !hold_tx_reg[3'(4'd7 - bit_reg)]);
  endproperty
  a_send_bit: assert property (p_send_bit) else $error("wrong data bit");

  property p_cmd_clear;
    @(posedge clk_i) disable iff (rst_i)
    done_evt |=> (cmd_reg == 4'h0);
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("command bit not cleared");

  property p_flags_clear;
    @(posedge clk_i) disable iff (rst_i)
    launch |=> (stat_reg == 4'h0) ##1 (stat_reg == 4'h0);
  endproperty
  a_flags_clear: assert property (p_flags_clear) else $error("flags not cleared");

  property p_cmd_done;
    @(posedge clk_i) disable iff (rst_i)
    (done_evt && (cmd_reg[`CMD_START_BIT] || cmd_reg[`CMD_STOP_BIT]))
      |=> stat_reg[`STAT_CMDFIN_BIT];
  endproperty
  a_cmd_done: assert property (p_cmd_done) else $error("command done not set");

  property p_tx_done;
    @(posedge clk_i) disable iff (rst_i)
    (done_evt && cmd_reg[`CMD_SEND_BIT])
      |=> (stat_reg[`STAT_TXFIN_BIT] && stat_reg[`STAT_NAK_BIT] == $past(nack_reg));
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("send result wrong");

  property p_rx_done;
    @(posedge clk_i) disable iff (rst_i)
    (done_evt && cmd_reg[`CMD_RECV_BIT])
      |=> (stat_reg[`STAT_RXFIN_BIT] && data_reg == $past(rxb_reg));
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive result wrong");

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
endmodule

// >>> tb/i2c_slave_model.sv
// behavioural two-wire bus slave: acks or nacks writes, sends bytes on reads, can stretch
`timescale 1ns/1ps
module i2c_slave_model (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic nack_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic [7:0] stretch_i,
  output logic scl_pull_o,
  output logic sda_pull_o,
  output logic [7:0] rx_byte_o,
  output logic mack_o,
  output logic [7:0] starts_o,
  output logic [7:0] stops_o
);
  logic [3:0] bitn = 4'h0;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] cur = 8'h00;
  initial begin
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    rx_byte_o = 8'h00;
    mack_o = 1'b0;
    starts_o = 8'h00;
    stops_o = 8'h00;
  end
  // ----------------------------------------------------------------
  // start and stop detection
  // ----------------------------------------------------------------
  always @(negedge sda_i) begin
    if (scl_i === 1'b1) begin
      starts_o = starts_o + 8'h01;
      bitn = 4'h0;
      first = 1'b1;
      rd = 1'b0;
    end
  end
  always @(posedge sda_i) begin
    if (scl_i === 1'b1) begin
      stops_o = stops_o + 8'h01;
      bitn = 4'h0;
      rd = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // bit sampling and driving
  // ----------------------------------------------------------------
  always @(posedge scl_i) begin
    if (bitn < 4'h8) begin
      sh = {sh[6:0], sda_i};
    end else if (rd) begin
      mack_o = sda_i;
    end
    bitn = bitn + 4'h1;
    if (bitn == 4'h8 && !rd) begin
      rx_byte_o = sh;
    end
  end
  always @(negedge scl_i) begin
    if (bitn == 4'h8) begin
      sda_pull_o = !rd && !nack_i;
    end else if (bitn == 4'h9) begin
      bitn = 4'h0;
      if (first) begin
        rd = sh[0];
      end else if (rd && mack_o) begin
        rd = 1'b0;
      end
      first = 1'b0;
      cur = tx_byte_i;
      sda_pull_o = rd && !cur[7];
    end else if (rd && bitn != 4'h0) begin
      sda_pull_o = !cur[3'h7 - bitn[2:0]];
    end
    if (stretch_i != 8'h00) begin
      scl_pull_o = 1'b1;
      #(stretch_i * 10);
      scl_pull_o = 1'b0;
    end
  end
endmodule

// >>> tb/i2c_master_segment_engine_tb_top.sv
// self-checking bench: wishbone master, slave model and read scoreboard
`timescale 1ns/1ps
`include "i2c_seg_map.svh"
module i2c_master_segment_engine_tb_top;
  logic clk_i, rst_i, link_clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, chk_rd, s_nack;
  logic scl_oe_o, sda_oe_o, s_scl, s_sda, s_mack, scl_w, sda_w, scl_o, sda_o;
  logic [7:0] wb_adr_i, s_tx, s_rx, s_starts, s_stops, s_str, cnt;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd_v, rng, r;
  logic [31:0] expq[$];
  logic [7:0] ofs[5] = '{`SEG_DATA_OFS, `SEG_STATUS_OFS, `SEG_CMD_OFS, `SEG_ACKCTL_OFS, 8'h00};
  int num_errors = 0;
  int tests_run = 0;
  assign scl_w = ((scl_oe_o === 1'b1) ? scl_o : 1'b1) & (s_scl !== 1'b1);
  assign sda_w = ((sda_oe_o === 1'b1) ? sda_o : 1'b1) & (s_sda !== 1'b1);
  i2c_master_segment_engine #(.QUARTER_CYCLES(4)) i2c_master_segment_engine_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
  i2c_slave_model i2c_slave_model_i (
    .scl_i(scl_w), .sda_i(sda_w), .nack_i(s_nack), .tx_byte_i(s_tx), .stretch_i(s_str),
    .scl_pull_o(s_scl), .sda_pull_o(s_sda), .rx_byte_o(s_rx), .mack_o(s_mack),
    .starts_o(s_starts), .stops_o(s_stops));
  // ----------------------------------------------------------------
  // clocks, watchdog and scoreboard
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #1.7;
    forever #3 link_clk_i = ~link_clk_i;
  end
  initial begin
    #400000;
    num_errors++;
    results();
  end
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && chk_rd && expq.size() > 0) begin
      check(wb_dat_o, expq.pop_front());
    end
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic fin(input string name);
    $display("test %0s finished", name);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d,
                    input logic chk, input logic [31:0] exp);
    int n;
    n = 0;
    if (chk) expq.push_back(exp);
    @(posedge clk_i);
    chk_rd <= chk;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd_v = wb_dat_o;
    if (n >= 50) check({31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic seg(input logic [3:0] cmd, input logic [31:0] st);
    int n;
    n = 0;
    wb(`SEG_CMD_OFS, 1'b1, {28'h0, cmd}, 1'b0, 32'h0);
    wb(`SEG_STATUS_OFS, 1'b0, xs(), 1'b1, 32'h0);
    wb(`SEG_CMD_OFS, 1'b0, xs(), 1'b1, {28'h0, cmd});
    do begin
      wb(`SEG_CMD_OFS, 1'b0, xs(), 1'b0, 32'h0);
      n++;
    end while (rd_v !== 32'h0 && n < 500);
    check(rd_v, 32'h0);
    wb(`SEG_STATUS_OFS, 1'b0, xs(), 1'b1, st);
  endtask
  task automatic send(input logic [7:0] b, input logic nk, input logic [31:0] st);
    s_nack = nk;
    wb(`SEG_DATA_OFS, 1'b1, {24'h0, b}, 1'b0, 32'h0);
    seg(4'h2, st);
    check({24'h0, s_rx}, {24'h0, b});
  endtask
  task automatic recv(input logic ack, input logic [7:0] b);
    wb(`SEG_ACKCTL_OFS, 1'b1, {31'h0, ack}, 1'b0, 32'h0);
    seg(4'h1, 32'h4);
    wb(`SEG_DATA_OFS, 1'b0, xs(), 1'b1, {24'h0, b});
    check({31'h0, s_mack}, {31'h0, !ack});
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rng = 32'h00000022;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    chk_rd = 1'b0;
    s_nack = 1'b0;
    s_tx = 8'h00;
    s_str = 8'h00;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) wb(ofs[i], 1'b0, xs(), 1'b1, 32'h0);
    wb(`SEG_ACKCTL_OFS, 1'b1, 32'h1, 1'b0, 32'h0);
    wb(`SEG_ACKCTL_OFS, 1'b0, xs(), 1'b1, 32'h1);
    fin("registers");
    r = xs();
    cnt = s_starts;
    seg(4'h4, 32'h8);
    check(32'(s_starts), 32'(cnt + 8'h01));
    send({r[6:0], 1'b0}, 1'b0, 32'h2);
    s_str = 8'h06;
    send(r[15:8], 1'b1, 32'h3);
    s_str = 8'h00;
    fin("seven bit address");
    seg(4'h4, 32'h8);
    send({5'h1E, r[9:8], 1'b0}, 1'b0, 32'h2);
    send(r[7:0], 1'b0, 32'h2);
    seg(4'h4, 32'h8);
    s_tx = r[23:16];
    send({5'h1E, r[9:8], 1'b1}, 1'b0, 32'h2);
    s_tx = r[31:24];
    recv(1'b1, r[23:16]);
    recv(1'b0, r[31:24]);
    fin("ten bit address and receive");
    cnt = s_stops;
    seg(4'h8, 32'h8);
    check(32'(s_stops), 32'(cnt + 8'h01));
    check({30'h0, scl_oe_o, sda_oe_o}, 32'h0);
    wb(`SEG_CMD_OFS, 1'b1, 32'h6, 1'b0, 32'h0);
    wb(`SEG_CMD_OFS, 1'b0, xs(), 1'b1, 32'h0);
    wb(`SEG_CMD_OFS, 1'b1, 32'h0, 1'b0, 32'h0);
    repeat (60) @(posedge clk_i);
    wb(`SEG_STATUS_OFS, 1'b0, xs(), 1'b1, 32'h8);
    check({30'h0, scl_oe_o, sda_oe_o}, 32'h0);
    fin("idle and illegal");
    results();
  end
endmodule
